/* dsp_pkg.sv */
// Purpose: shared constants and types for the dual-slope pwm timer
// Assumes: apb with 32-bit data, one aligned word per register
// Notes:   offsets are byte addresses
package dsp_pkg;
    // ************************************************************
    // register offsets
    // ************************************************************
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_CMP_A   = 8'h04;
    localparam logic [7:0] OFS_CMP_B   = 8'h08;
    localparam logic [7:0] OFS_CAP_TOP = 8'h0C;
    localparam logic [7:0] OFS_COUNT   = 8'h10;
    localparam logic [7:0] OFS_FLAGS   = 8'h14;

    // ************************************************************
    // control and flag field positions
    // ************************************************************
    localparam int CTRL_WAVE_LSB = 0;
    localparam int CTRL_ACTA_LSB = 4;
    localparam int CTRL_ACTB_LSB = 6;
    localparam int CTRL_PRE_LSB  = 8;
    localparam int CTRL_DIRA_BIT = 12;
    localparam int CTRL_DIRB_BIT = 13;
    localparam int FLG_OVF_BIT   = 0;
    localparam int FLG_CMPA_BIT  = 1;
    localparam int FLG_CMPB_BIT  = 2;
    localparam int FLG_CAP_BIT   = 3;

    // ************************************************************
    // reset values and fixed tops
    // ************************************************************
    localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;
    localparam logic [15:0] CMP_RESET   = 16'h0000;
    localparam logic [15:0] TOP_8BIT    = 16'h00FF;
    localparam logic [15:0] TOP_9BIT    = 16'h01FF;
    localparam logic [15:0] TOP_10BIT   = 16'h03FF;
    localparam logic [15:0] BOTTOM      = 16'h0000;

    // ************************************************************
    // prescaler divide counts (selection 2..5)
    // ************************************************************
    localparam logic [9:0] DIV_8    = 10'h007;
    localparam logic [9:0] DIV_64   = 10'h03F;
    localparam logic [9:0] DIV_256  = 10'h0FF;
    localparam logic [9:0] DIV_1024 = 10'h3FF;

    // ************************************************************
    // waveform selections and output actions
    // ************************************************************
    localparam logic [3:0] WAVE_PC8   = 4'h1;
    localparam logic [3:0] WAVE_PC9   = 4'h2;
    localparam logic [3:0] WAVE_PC10  = 4'h3;
    localparam logic [3:0] WAVE_PFC_C = 4'h8;
    localparam logic [3:0] WAVE_PFC_A = 4'h9;
    localparam logic [3:0] WAVE_PC_C  = 4'hA;
    localparam logic [3:0] WAVE_PC_A  = 4'hB;

    typedef enum logic [1:0] {
        ACT_OFF,
        ACT_TOGGLE,
        ACT_NONINV,
        ACT_INV
    } dsp_action_t;

    typedef struct packed {
        logic [3:0] waveform_select;
        logic [1:0] output_action_a;
        logic [1:0] output_action_b;
        logic [2:0] prescale;
        logic       pin_direction_bit_a;
        logic       pin_direction_bit_b;
    } dsp_ctrl_t;
endpackage : dsp_pkg

/* dsp_timer.sv */
// Purpose: 16-bit dual-slope pwm timer with apb register access
// Assumes: pclk is the i/o clock; prescaler factors 1, 8, 64, 256, 1024
// Notes:   two compare channels, a and b; no interrupt logic
`timescale 1ns/1ps

module dsp_timer (
    input  wire logic        pclk,          // i/o clock, 250 MHz
    input  wire logic        presetn,       // async reset, active low
    input  wire logic        psel,          // apb select
    input  wire logic        penable,       // apb access phase
    input  wire logic        pwrite,        // apb write
    input  wire logic [7:0]  paddr,         // apb byte address
    input  wire logic [31:0] pwdata,        // apb write data
    input  wire logic [3:0]  pstrb,         // apb byte strobes
    output logic      [31:0] prdata,        // apb read data
    output logic             pready,        // apb ready
    output logic             pslverr,       // apb error on unmapped address
    input  wire logic [1:0]  port_value,    // normal port level per pin
    output logic      [1:0]  pin_out,       // pin level, a in bit 0
    output logic      [1:0]  pin_oe         // pin driver enable
);
    // ************************************************************
    // apb decode
    // ************************************************************
    logic        setup_ff;
    wire         acc    = psel & penable & setup_ff;
    wire         wr     = acc & pwrite;
    wire         hit_ct = (paddr == dsp_pkg::OFS_CTRL);
    wire         hit_a  = (paddr == dsp_pkg::OFS_CMP_A);
    wire         hit_b  = (paddr == dsp_pkg::OFS_CMP_B);
    wire         hit_c  = (paddr == dsp_pkg::OFS_CAP_TOP);
    wire         hit_n  = (paddr == dsp_pkg::OFS_COUNT);
    wire         hit_f  = (paddr == dsp_pkg::OFS_FLAGS);
    wire         mapped = hit_ct | hit_a | hit_b | hit_c | hit_n | hit_f;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
            if (st[i]) r[i*8 +: 8] = nw[i*8 +: 8];
        return r;
    endfunction : merge

    // ************************************************************
    // registers
    // ************************************************************
    logic [31:0]       ctrl_ff;
    logic [15:0]       buf_a_ff;
    logic [15:0]       buf_b_ff;
    logic [15:0]       cmp_a_ff;
    logic [15:0]       cmp_b_ff;
    logic [15:0]       cap_ff;
    logic [15:0]       cnt_ff;
    logic              down_ff;
    logic [3:0]        flag_ff;
    logic [1:0]        oc_ff;
    logic [9:0]        pre_ff;
    logic              tick_ff;
    dsp_pkg::dsp_ctrl_t cfg;

    assign cfg.waveform_select     = ctrl_ff[dsp_pkg::CTRL_WAVE_LSB +: 4];
    assign cfg.output_action_a     = ctrl_ff[dsp_pkg::CTRL_ACTA_LSB +: 2];
    assign cfg.output_action_b     = ctrl_ff[dsp_pkg::CTRL_ACTB_LSB +: 2];
    assign cfg.prescale            = ctrl_ff[dsp_pkg::CTRL_PRE_LSB +: 3];
    assign cfg.pin_direction_bit_a = ctrl_ff[dsp_pkg::CTRL_DIRA_BIT];
    assign cfg.pin_direction_bit_b = ctrl_ff[dsp_pkg::CTRL_DIRB_BIT];

    // ************************************************************
    // mode decode
    // ************************************************************
    wire [3:0] ws      = cfg.waveform_select;
    wire       pc_mode = (ws == dsp_pkg::WAVE_PC8) | (ws == dsp_pkg::WAVE_PC9)
                       | (ws == dsp_pkg::WAVE_PC10) | (ws == dsp_pkg::WAVE_PC_C)
                       | (ws == dsp_pkg::WAVE_PC_A);
    wire       pfc_mode = (ws == dsp_pkg::WAVE_PFC_C) | (ws == dsp_pkg::WAVE_PFC_A);
    wire       dual    = pc_mode | pfc_mode;
    wire       top_a   = (ws == dsp_pkg::WAVE_PC_A) | (ws == dsp_pkg::WAVE_PFC_A);
    wire       top_c   = (ws == dsp_pkg::WAVE_PC_C) | (ws == dsp_pkg::WAVE_PFC_C);
    wire       fixed   = (ws == dsp_pkg::WAVE_PC8) | (ws == dsp_pkg::WAVE_PC9)
                       | (ws == dsp_pkg::WAVE_PC10);

    // fixed tops double as the write mask
    wire [15:0] fix_top = (ws == dsp_pkg::WAVE_PC8) ? dsp_pkg::TOP_8BIT :
                          (ws == dsp_pkg::WAVE_PC9) ? dsp_pkg::TOP_9BIT :
                                                      dsp_pkg::TOP_10BIT;
    // top compared against the live compare a, which only moves at a reload
    wire [15:0] top = top_a ? cmp_a_ff :
                      top_c ? cap_ff  : fix_top;

    // ************************************************************
    // prescaler
    // ************************************************************
    wire [9:0] div_max = (cfg.prescale == 3'h2) ? dsp_pkg::DIV_8 :
                         (cfg.prescale == 3'h3) ? dsp_pkg::DIV_64 :
                         (cfg.prescale == 3'h4) ? dsp_pkg::DIV_256 :
                         (cfg.prescale == 3'h5) ? dsp_pkg::DIV_1024 : 10'h000;
    wire       run     = (cfg.prescale != 3'h0) & (cfg.prescale < 3'h6);
    wire       pre_end = (pre_ff >= div_max);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pre_ff  <= 10'h000;
            tick_ff <= 1'b0;
        end
        else
        begin
            pre_ff  <= (!run || pre_end) ? 10'h000 : pre_ff + 10'h001;
            tick_ff <= run & pre_end;
        end
    end

    // ************************************************************
    // counter and events
    // ************************************************************
    wire at_top    = (cnt_ff == top);
    wire at_bot    = (cnt_ff == dsp_pkg::BOTTOM);
    wire tk        = tick_ff & dual;
    // at top the count stays one tick, then falls
    wire nxt_down  = at_top ? 1'b1 : (at_bot ? 1'b0 : down_ff);
    wire [15:0] nxt_cnt = nxt_down ? cnt_ff - 16'h0001 : cnt_ff + 16'h0001;
    wire reload    = tk & ((pc_mode & at_top) | (pfc_mode & at_bot));
    wire ev_ovf    = tk & at_bot;
    wire ev_top    = tk & at_top & (top_a | top_c) & !(at_top & down_ff);
    wire m_a       = tk & (cnt_ff == cmp_a_ff);
    wire m_b       = tk & (cnt_ff == cmp_b_ff);
    wire [15:0] wmask = fixed ? fix_top : 16'hFFFF;
    wire [31:0] wdat  = merge(32'h0, pwdata, pstrb);
    wire [31:0] wd_a  = merge({16'h0, buf_a_ff}, pwdata, pstrb);
    wire [31:0] wd_b  = merge({16'h0, buf_b_ff}, pwdata, pstrb);
    wire [31:0] wd_c  = merge({16'h0, cap_ff}, pwdata, pstrb);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_ff  <= dsp_pkg::BOTTOM;
            down_ff <= 1'b0;
        end
        else if (wr && hit_n)
        begin
            cnt_ff  <= wdat[15:0];
            down_ff <= 1'b0;
        end
        else if (tk)
        begin
            // top held once: the tick at top already turns the count downward
            cnt_ff  <= nxt_cnt;
            down_ff <= nxt_down;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_ff  <= dsp_pkg::CTRL_RESET;
            buf_a_ff <= dsp_pkg::CMP_RESET;
            buf_b_ff <= dsp_pkg::CMP_RESET;
            cap_ff   <= dsp_pkg::CMP_RESET;
        end
        else if (wr)
        begin
            if (hit_ct) ctrl_ff <= merge(ctrl_ff, pwdata, pstrb) & 32'h0000_3FFF;
            if (hit_a)  buf_a_ff <= wd_a[15:0] & wmask;
            if (hit_b)  buf_b_ff <= wd_b[15:0] & wmask;
            if (hit_c)  cap_ff   <= wd_c[15:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cmp_a_ff <= dsp_pkg::CMP_RESET;
            cmp_b_ff <= dsp_pkg::CMP_RESET;
        end
        else if (reload || !dual)
        begin
            cmp_a_ff <= buf_a_ff;
            cmp_b_ff <= buf_b_ff;
        end
    end

    // ************************************************************
    // flags: set beats write-one-to-clear
    // ************************************************************
    wire [3:0] flag_set;
    assign flag_set[dsp_pkg::FLG_OVF_BIT]  = ev_ovf;
    assign flag_set[dsp_pkg::FLG_CMPA_BIT] = m_a | (ev_top & top_a);
    assign flag_set[dsp_pkg::FLG_CMPB_BIT] = m_b;
    assign flag_set[dsp_pkg::FLG_CAP_BIT]  = ev_top & top_c;
    wire [3:0] flag_clr = (wr && hit_f && pstrb[0]) ? pwdata[3:0] : 4'h0;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            flag_ff <= 4'h0;
        else
            flag_ff <= (flag_ff & ~flag_clr) | flag_set;
    end

    // ************************************************************
    // waveform per channel
    // ************************************************************
    wire [1:0]  act [2];
    wire [1:0]  hit;
    wire [15:0] cmpv [2];
    assign act[0]  = cfg.output_action_a;
    assign act[1]  = cfg.output_action_b;
    assign hit     = {m_b, m_a};
    assign cmpv[0] = cmp_a_ff;
    assign cmpv[1] = cmp_b_ff;
    wire   tog_ok  = ws[3] & dual;
    // a bottom match clears and a top match sets (the reverse for ACT_INV), so 0 and top give flat levels
    wire   going_up = at_bot | (!down_ff & !at_top);

    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_ch
            wire tog = (act[g] == 2'(dsp_pkg::ACT_TOGGLE)) & tog_ok & (g == 0);
            wire pwm = act[g][1];
            wire inv = (act[g] == 2'(dsp_pkg::ACT_INV));
            wire lvl = (going_up ? 1'b0 : 1'b1) ^ inv;
            wire con = (pwm | tog) & cfg.waveform_select != 4'h0;
            wire dir = g ? cfg.pin_direction_bit_b : cfg.pin_direction_bit_a;
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    oc_ff[g] <= 1'b0;
                else if (hit[g] && tog)
                    oc_ff[g] <= ~oc_ff[g];
                else if (hit[g] && pwm && dual)
                    oc_ff[g] <= lvl;
            end
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    pin_out[g] <= 1'b0;
                    pin_oe[g]  <= 1'b0;
                end
                else
                begin
                    pin_out[g] <= (con && dual) ? oc_ff[g] : port_value[g];
                    pin_oe[g]  <= dir;
                end
            end
        end
    endgenerate

    // ************************************************************
    // apb response
    // ************************************************************
    wire [31:0] rd = hit_ct ? ctrl_ff :
                     hit_a  ? {16'h0, buf_a_ff} :
                     hit_b  ? {16'h0, buf_b_ff} :
                     hit_c  ? {16'h0, cap_ff} :
                     hit_n  ? {16'h0, cnt_ff} :
                     hit_f  ? {28'h0, flag_ff} : 32'h0;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            setup_ff <= 1'b0;
            pready   <= 1'b0;
            pslverr  <= 1'b0;
            prdata   <= 32'h0000_0000;
        end
        else
        begin
            // answer in the first cycle of the access phase
            setup_ff <= psel & !penable;
            pready   <= psel & !penable;
            pslverr  <= psel & !penable & !mapped;
            prdata   <= (psel && !penable && !pwrite) ? rd : 32'h0000_0000;
        end
    end
endmodule : dsp_timer

/* dsp_timer_assertions.sv */
// Purpose: port-level checks for dsp_timer
// Assumes: control written with all byte strobes
// Notes:   control is shadowed from accepted apb writes
`timescale 1ns/1ps
module dsp_chk (
    input wire logic        pclk,       // clock
    input wire logic        presetn,    // reset, active low
    input wire logic        psel,       // apb select
    input wire logic        penable,    // apb enable
    input wire logic        pwrite,     // apb write
    input wire logic [7:0]  paddr,      // apb address
    input wire logic [31:0] pwdata,     // apb write data
    input wire logic [3:0]  pstrb,      // apb strobes
    input wire logic [31:0] prdata,     // apb read data
    input wire logic        pready,     // apb ready
    input wire logic        pslverr,    // apb error
    input wire logic [1:0]  port_value, // port level
    input wire logic [1:0]  pin_out,    // pin level
    input wire logic [1:0]  pin_oe      // pin enable
);
    logic [13:0] ctl_ff;
    logic [2:0]  qt_ff;
    wire         wr_acc = psel && penable && pready && pwrite && !pslverr;
    wire         dual   = ctl_ff[3] && ctl_ff[2:0] <= 3'h3;
    wire         a_off  = ctl_ff[5:4] == 2'h0 || (ctl_ff[5:4] == 2'h1 && !dual);
    wire         b_off  = !ctl_ff[7];
    wire         quiet  = qt_ff >= 3'h3;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctl_ff <= 14'h0000;
            qt_ff  <= 3'h0;
        end
        else
        begin
            if (wr_acc && paddr == dsp_pkg::OFS_CTRL)
                ctl_ff <= pwdata[13:0];
            qt_ff <= wr_acc ? 3'h0 : qt_ff + {2'h0, qt_ff != 3'h7};
        end
    end
    // ************************************************************
    // properties
    // ************************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_rdy_pulse; pready |=> !pready; endproperty
    property p_rdy_next; psel && !penable |=> pready; endproperty
    property p_rdy_cause; pready |-> $past(psel) && !$past(penable); endproperty
    property p_err_map;
        pready |-> pslverr == (paddr > dsp_pkg::OFS_FLAGS || paddr[1:0] != 2'h0);
    endproperty
    property p_err_data; pslverr |-> pready && prdata == 32'h0; endproperty
    property p_oe_dir; qt_ff != 3'h0 |-> pin_oe == ctl_ff[13:12]; endproperty
    property p_pass_a;
        (quiet && a_off && $stable(port_value)) [*3] |-> pin_out[0] == port_value[0];
    endproperty
    property p_pass_b;
        (quiet && b_off && $stable(port_value)) [*3] |-> pin_out[1] == port_value[1];
    endproperty
    property p_stop;
        (quiet && ctl_ff[10:8] == 3'h0 && $stable(port_value)) [*3] |=> $stable(pin_out);
    endproperty
    a_rdy_pulse: assert property (p_rdy_pulse) else $error("pready too long");
    a_rdy_next: assert property (p_rdy_next) else $error("no answer after setup");
    a_rdy_cause: assert property (p_rdy_cause) else $error("pready without setup");
    a_err_map: assert property (p_err_map) else $error("pslverr wrong for address");
    a_err_data: assert property (p_err_data) else $error("error answer with data");
    a_oe_dir: assert property (p_oe_dir) else $error("pin_oe not direction");
    a_pass_a: assert property (p_pass_a) else $error("pin a not port level");
    a_pass_b: assert property (p_pass_b) else $error("pin b not port level");
    a_stop: assert property (p_stop) else $error("pins move while stopped");
    c_ctl: cover property (wr_acc && paddr == dsp_pkg::OFS_CTRL);
    c_err: cover property (pslverr);
    c_pwm: cover property ($rose(pin_out[1]) && pin_oe[1]);
endmodule : dsp_chk
bind dsp_timer dsp_chk dsp_chk_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .port_value(port_value),
    .pin_out(pin_out), .pin_oe(pin_oe));

/* dsp_load.sv */
// Purpose: external load on the two pwm pins
// Assumes: pins pulled down while undriven
// Notes:   counts high cycles over a window
`timescale 1ns/1ps
module dsp_load (
    input wire logic        pclk,    // clock
    input wire logic [1:0]  pin_out, // pin levels
    input wire logic [1:0]  pin_oe,  // pin enables
    input wire logic        start,   // open a window
    input wire logic [15:0] win,     // window length
    output logic     [15:0] hi_a,    // high cycles, pin a
    output logic     [15:0] hi_b,    // high cycles, pin b
    output logic            done     // window closed
);
    logic [15:0] left;
    wire  [1:0]  lvl = pin_out & pin_oe;
    initial
    begin
        left = 16'h0000;
        hi_a = 16'h0000;
        hi_b = 16'h0000;
        done = 1'b0;
    end
    always @(posedge pclk)
    begin
        done <= 1'b0;
        if (start)
        begin
            left <= win;
            hi_a <= 16'h0000;
            hi_b <= 16'h0000;
        end
        else if (left != 16'h0000)
        begin
            left <= left - 16'h0001;
            hi_a <= hi_a + {15'h0000, lvl[0]};
            hi_b <= hi_b + {15'h0000, lvl[1]};
            done <= left == 16'h0001;
        end
    end
endmodule : dsp_load

/* tb_top.sv */
// Purpose: self-checking bench for dsp_timer
// Assumes: one access cycle per apb transfer
// Notes:   duty measured over four pwm periods
`timescale 1ns/1ps
module tb_top;
    typedef struct packed { logic wr; logic err; logic [31:0] dat; } dsp_note_t;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, start, done;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, seed, rv;
    logic [3:0]  pstrb;
    logic [1:0]  port_value, pin_out, pin_oe;
    logic [15:0] win, hi_a, hi_b;
    dsp_note_t   apb_q[$];
    logic [16:0] pin_q[$];
    int          err_count, checked;
    dsp_timer dsp_timer_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .port_value(port_value), .pin_out(pin_out),
        .pin_oe(pin_oe));
    dsp_load dsp_load_inst (.pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe), .start(start),
        .win(win), .hi_a(hi_a), .hi_b(hi_b), .done(done));
    always #2 pclk = ~pclk;
    // ************************************************************
    // compare and bus tasks
    // ************************************************************
    task automatic bad(input logic [31:0] got, input logic [31:0] exp);
        err_count++;
        $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    endtask : bad
    task automatic cmp_apb(input dsp_note_t n);
        checked++;
        if (pslverr !== n.err || (!n.wr && prdata !== n.dat))
            bad({pslverr, prdata[30:0]}, {n.err, n.dat[30:0]});
    endtask : cmp_apb
    task automatic cmp_pin(input logic [16:0] n);
        checked++;
        if ((n[16] ? hi_b : hi_a) !== n[15:0])
            bad({16'h0000, n[16] ? hi_b : hi_a}, {16'h0000, n[15:0]});
    endtask : cmp_pin
    always @(posedge pclk)
    begin
        if (pready === 1'b1 && apb_q.size() > 0)
            cmp_apb(apb_q.pop_front());
        if (done === 1'b1 && pin_q.size() > 0)
            cmp_pin(pin_q.pop_front());
    end
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] e, input logic er);
        apb_q.push_back('{w, er, e});
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // only the watchdog ends a wait that never gets an answer
        do
            @(posedge pclk);
        while (pready !== 1'b1);
    endtask : apb
    task automatic idle();
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : idle
    // one pwm setting, settled, then measured on one pin
    task automatic run(input logic [3:0] wv, input logic ch, input logic [1:0] act,
                       input logic [2:0] pre, input int top, input int cv);
        int nd, w, e;
        nd = (pre == 3'h1) ? 1 : 8;
        w  = 8 * top * nd;
        rv = $random(seed);
        e  = (act == 2'h1 && !ch) ? 4 * top * nd : (act == 2'h2) ? 8 * cv * nd :
             (act == 2'h3) ? 8 * (top - cv) * nd : (rv[ch] ? w : 0);
        port_value <= rv[1:0];
        apb(1'b1, dsp_pkg::OFS_CTRL, {18'h0, 2'h3, 8'h0, wv}, 32'h0, 1'b0);
        apb(1'b1, dsp_pkg::OFS_CAP_TOP, top, 32'h0, 1'b0);
        apb(1'b1, dsp_pkg::OFS_CMP_A, top, 32'h0, 1'b0);
        apb(1'b1, dsp_pkg::OFS_CMP_B, ch ? cv : 0, 32'h0, 1'b0);
        apb(1'b1, dsp_pkg::OFS_COUNT, 32'h0, 32'h0, 1'b0);
        apb(1'b1, dsp_pkg::OFS_FLAGS, 32'hF, 32'h0, 1'b0);
        apb(1'b1, dsp_pkg::OFS_CTRL, {18'h0, 2'h3, 1'b0, pre, ch ? act : 2'h0,
            ch ? 2'h0 : act, wv}, 32'h0, 1'b0);
        idle();
        repeat (4 * top * nd + 8) @(posedge pclk);
        pin_q.push_back({ch, e[15:0]});
        start <= 1'b1;
        win   <= w[15:0];
        @(posedge pclk);
        start <= 1'b0;
        while (done !== 1'b1)
            @(posedge pclk);
        apb(1'b0, dsp_pkg::OFS_FLAGS, 32'h0, {28'h0, wv == 4'h8 || wv == 4'hA, 3'h7},
            1'b0);
        idle();
    endtask : run
    task automatic results();
        $display("errors %0d compares %0d", err_count, checked);
        if (err_count == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : results
    // ************************************************************
    // main sequence
    // ************************************************************
    initial
    begin
        pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 8'h00;
        pwdata = 32'h0; pstrb = 4'hF; port_value = 2'h0; start = 0; win = 16'h0000;
        seed = 32'h4f2fa3e7; err_count = 0; checked = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, dsp_pkg::OFS_CTRL, 32'h0, dsp_pkg::CTRL_RESET, 1'b0);
        apb(1'b0, dsp_pkg::OFS_CMP_A, 32'h0, {16'h0, dsp_pkg::CMP_RESET}, 1'b0);
        apb(1'b0, dsp_pkg::OFS_FLAGS, 32'h0, 32'h0, 1'b0);
        apb(1'b0, 8'h18, 32'h0, 32'h0, 1'b1);
        apb(1'b1, 8'h1C, 32'h5, 32'h0, 1'b1);
        for (int i = 0; i < 3; i++)
        begin
            rv = $random(seed);
            apb(1'b1, dsp_pkg::OFS_CTRL, i + 1, 32'h0, 1'b0);
            apb(1'b1, dsp_pkg::OFS_CMP_B, rv, 32'h0, 1'b0);
            apb(1'b0, dsp_pkg::OFS_CMP_B, 32'h0, rv[15:0] & ((32'h100 << i) - 1), 1'b0);
        end
        idle();
        repeat (8) @(posedge pclk);
        run(dsp_pkg::WAVE_PFC_C, 1'b1, 2'h2, 3'h1, 40, 10);
        run(dsp_pkg::WAVE_PFC_A, 1'b1, 2'h3, 3'h1, 40, 0);
        run(dsp_pkg::WAVE_PC_C, 1'b1, 2'h2, 3'h1, 40, 40);
        run(dsp_pkg::WAVE_PC_C, 1'b1, 2'h2, 3'h1, 40, 0);
        run(dsp_pkg::WAVE_PC_A, 1'b1, 2'h3, 3'h2, 40, 13);
        run(dsp_pkg::WAVE_PC_A, 1'b0, 2'h1, 3'h1, 40, 0);
        run(dsp_pkg::WAVE_PFC_A, 1'b0, 2'h1, 3'h1, 40, 0);
        run(dsp_pkg::WAVE_PC8, 1'b1, 2'h2, 3'h1, 255, 100);
        run(dsp_pkg::WAVE_PC_C, 1'b1, 2'h1, 3'h1, 40, 0);
        run(dsp_pkg::WAVE_PC_C, 1'b1, 2'h0, 3'h1, 40, 0);
        results();
    end
    initial
    begin
        #200000;
        err_count++;
        results();
    end
endmodule : tb_top
